/* File: ccd_pkg.sv */
// Constants for the channel clock divider: register map, fields, resets, states.
// Assumes one system clock that stands for the divider input clock.
package ccd_pkg;
   // Register offsets
   localparam logic [9:0] ADDR_PHASE_COUNTS = 10'h190;
   localparam logic [9:0] ADDR_DIV_CONTROL = 10'h191;
   localparam logic [9:0] ADDR_ROUTING_POWER = 10'h192;
   // Reset values
   localparam logic [7:0] RST_PHASE_COUNTS = 8'h77;
   localparam logic [7:0] RST_DIV_CONTROL = 8'h00;
   localparam logic [2:0] RST_ROUTING_POWER = 3'h0;
   // Field positions
   localparam int LOW_MSB = 7;
   localparam int LOW_LSB = 4;
   localparam int HIGH_MSB = 3;
   localparam int HIGH_LSB = 0;
   localparam int BIT_BYPASS = 7;
   localparam int BIT_IGNORE_SYNC = 6;
   localparam int BIT_FORCE_HIGH = 5;
   localparam int BIT_START_HIGH = 4;
   localparam int OFS_MSB = 3;
   localparam int OFS_LSB = 0;
   localparam int BIT_POWER_DOWN = 2;
   localparam int BIT_DIRECT = 1;
   localparam int BIT_DCC_OFF = 0;
   localparam int ROUTING_BITS = 3;
   // Pin synchroniser depth
   localparam int SYNC_STAGES = 3;
   typedef enum logic [1:0] {
      ST_HOLD = 2'b00,
      ST_DELAY = 2'b01,
      ST_LOW = 2'b10,
      ST_HIGH = 2'b11
   } ccd_state_t;
endpackage

/* File: ccd_channel_clock_divider.sv */
// Channel clock divider: low/high counts, bypass, sync, force, phase offset,
// power-down, direct routing and duty-cycle fix control for one channel.
// Assumes i_sys_clk is the divider input clock; outputs are one sample per input cycle.
`timescale 1ns/1ps
module ccd_channel_clock_divider (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_resetn,
   // Register port
   input wire logic [9:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   output logic [7:0] o_reg_rdata,
   // Chip-level controls
   input wire logic i_sync_n,
   input wire logic i_global_route_block,
   // Outputs
   output logic o_div_clk,
   output logic o_channel_output_a,
   output logic o_channel_output_b,
   output logic o_channel_output_c,
   output logic o_chan_powered_down,
   output logic o_duty_cycle_fix_on
);
   ////////////////////////////////////////////////////////////////////////////
   logic [1:0] rst_pipe_q;
   logic rst_n;
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rst_pipe_q <= 2'h0;
      end else begin
         rst_pipe_q <= {rst_pipe_q[0], 1'b1};
      end
   end
   assign rst_n = rst_pipe_q[1];

   ////////////////////////////////////////////////////////////////////////////
   logic [7:0] phase_q;
   logic [7:0] ctl_q;
   logic [ccd_pkg::ROUTING_BITS-1:0] route_q;
   always_ff @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         phase_q <= ccd_pkg::RST_PHASE_COUNTS;
         ctl_q <= ccd_pkg::RST_DIV_CONTROL;
         route_q <= ccd_pkg::RST_ROUTING_POWER;
      end else if (i_reg_wr) begin
         if (i_reg_addr == ccd_pkg::ADDR_PHASE_COUNTS) begin
            phase_q <= i_reg_wdata;
         end
         if (i_reg_addr == ccd_pkg::ADDR_DIV_CONTROL) begin
            ctl_q <= i_reg_wdata;
         end
         if (i_reg_addr == ccd_pkg::ADDR_ROUTING_POWER) begin
            route_q <= i_reg_wdata[ccd_pkg::ROUTING_BITS-1:0];
         end
      end
   end

   // Unmapped reads and reserved bits return zero
   always_ff @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_reg_rdata <= 8'h00;
      end else if (i_reg_rd) begin
         case (i_reg_addr)
            ccd_pkg::ADDR_PHASE_COUNTS: o_reg_rdata <= phase_q;
            ccd_pkg::ADDR_DIV_CONTROL: o_reg_rdata <= ctl_q;
            ccd_pkg::ADDR_ROUTING_POWER: o_reg_rdata <= {5'h00, route_q};
            default: o_reg_rdata <= 8'h00;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sync pin: three stages, a change counts once stages two and three agree
   logic [ccd_pkg::SYNC_STAGES-1:0] sync_pipe_q;
   logic sync_act_q;
   always_ff @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sync_pipe_q <= 3'h7;
         sync_act_q <= 1'b0;
      end else begin
         sync_pipe_q <= {sync_pipe_q[1:0], i_sync_n};
         if (sync_pipe_q[1] == sync_pipe_q[2]) begin
            sync_act_q <= ~sync_pipe_q[2];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   logic bypass;
   logic ignore_sync;
   logic forced;
   logic power_down;
   logic direct;
   logic hold_req;
   assign bypass = ctl_q[ccd_pkg::BIT_BYPASS];
   assign ignore_sync = ctl_q[ccd_pkg::BIT_IGNORE_SYNC];
   // Static level only takes hold with ignore-sync also set
   assign forced = ignore_sync & ctl_q[ccd_pkg::BIT_FORCE_HIGH];
   assign power_down = route_q[ccd_pkg::BIT_POWER_DOWN];
   assign direct = route_q[ccd_pkg::BIT_DIRECT] & ~i_global_route_block;
   assign hold_req = (sync_act_q & ~ignore_sync) | power_down;

   ccd_pkg::ccd_state_t state_q;
   logic [3:0] cnt_q;
   always_ff @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ccd_pkg::ST_DELAY;
         cnt_q <= 4'h0;
      end else if (bypass || hold_req) begin
         state_q <= ccd_pkg::ST_HOLD;
         cnt_q <= ctl_q[ccd_pkg::OFS_MSB:ccd_pkg::OFS_LSB];
      end else begin
         case (state_q)
            ccd_pkg::ST_HOLD: begin
               state_q <= ccd_pkg::ST_DELAY;
               cnt_q <= ctl_q[ccd_pkg::OFS_MSB:ccd_pkg::OFS_LSB];
            end
            ccd_pkg::ST_DELAY: begin
               if (cnt_q == 4'h0) begin
                  if (ctl_q[ccd_pkg::BIT_START_HIGH]) begin
                     state_q <= ccd_pkg::ST_HIGH;
                     cnt_q <= phase_q[ccd_pkg::HIGH_MSB:ccd_pkg::HIGH_LSB];
                  end else begin
                     state_q <= ccd_pkg::ST_LOW;
                     cnt_q <= phase_q[ccd_pkg::LOW_MSB:ccd_pkg::LOW_LSB];
                  end
               end else begin
                  cnt_q <= cnt_q - 4'h1;
               end
            end
            ccd_pkg::ST_LOW: begin
               if (cnt_q == 4'h0) begin
                  state_q <= ccd_pkg::ST_HIGH;
                  cnt_q <= phase_q[ccd_pkg::HIGH_MSB:ccd_pkg::HIGH_LSB];
               end else begin
                  cnt_q <= cnt_q - 4'h1;
               end
            end
            ccd_pkg::ST_HIGH: begin
               if (cnt_q == 4'h0) begin
                  state_q <= ccd_pkg::ST_LOW;
                  cnt_q <= phase_q[ccd_pkg::LOW_MSB:ccd_pkg::LOW_LSB];
               end else begin
                  cnt_q <= cnt_q - 4'h1;
               end
            end
            default: begin
               state_q <= ccd_pkg::ST_HOLD;
               cnt_q <= 4'h0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Input clock is shown as a level toggling every cycle, since a flop
   // cannot carry the clock itself
   always_ff @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_div_clk <= 1'b0;
      end else if (bypass) begin
         o_div_clk <= ~o_div_clk;
      end else if (forced) begin
         o_div_clk <= 1'b1;
      end else if (state_q == ccd_pkg::ST_HOLD || state_q == ccd_pkg::ST_DELAY) begin
         o_div_clk <= ctl_q[ccd_pkg::BIT_START_HIGH];
      end else begin
         o_div_clk <= (state_q == ccd_pkg::ST_HIGH);
      end
   end

   logic chan_d;
   assign chan_d = direct ? ~o_channel_output_a : o_div_clk;
   always_ff @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_channel_output_a <= 1'b0;
         o_channel_output_b <= 1'b0;
         o_channel_output_c <= 1'b0;
         o_chan_powered_down <= 1'b0;
      end else begin
         o_channel_output_a <= chan_d & ~power_down;
         o_channel_output_b <= chan_d & ~power_down;
         o_channel_output_c <= chan_d & ~power_down;
         o_chan_powered_down <= power_down;
      end
   end

   // Correction acts on analog edges; only its enable is visible here
   always_ff @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_duty_cycle_fix_on <= 1'b0;
      end else begin
         o_duty_cycle_fix_on <= ~route_q[ccd_pkg::BIT_DCC_OFF] & ~bypass & ~power_down;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!rst_n);

   AST_LOW_LEN: assert property (
      (state_q == ccd_pkg::ST_HIGH && cnt_q == 4'h0 && !bypass && !hold_req)
      |=> (state_q == ccd_pkg::ST_LOW && cnt_q == $past(phase_q[ccd_pkg::LOW_MSB:ccd_pkg::LOW_LSB])))
      else $error("low phase not loaded from low count");
   AST_HIGH_LEN: assert property (
      (state_q == ccd_pkg::ST_LOW && cnt_q == 4'h0 && !bypass && !hold_req)
      |=> (state_q == ccd_pkg::ST_HIGH && cnt_q == $past(phase_q[ccd_pkg::HIGH_MSB:ccd_pkg::HIGH_LSB])))
      else $error("high phase not loaded from high count");
   AST_BYPASS_TOGGLE: assert property (
      bypass ##1 bypass |-> (o_div_clk != $past(o_div_clk) && state_q == ccd_pkg::ST_HOLD))
      else $error("bypass does not pass input clock");
   AST_SYNC_OBEY: assert property (
      (sync_act_q && !ignore_sync && !bypass) |=> state_q == ccd_pkg::ST_HOLD)
      else $error("sync not obeyed");
   AST_SYNC_IGNORE: assert property (
      (ignore_sync && !power_down && !bypass) |=> state_q != ccd_pkg::ST_HOLD)
      else $error("sync not ignored");
   AST_FORCE: assert property (
      (forced && !bypass) |=> o_div_clk)
      else $error("force high not applied");
   AST_START_LEVEL: assert property (
      (state_q == ccd_pkg::ST_DELAY && !bypass && !forced)
      |=> o_div_clk == $past(ctl_q[ccd_pkg::BIT_START_HIGH]))
      else $error("start level wrong");
   AST_OFFSET: assert property (
      (state_q == ccd_pkg::ST_HOLD && !bypass && !hold_req)
      |=> (state_q == ccd_pkg::ST_DELAY && cnt_q == $past(ctl_q[ccd_pkg::OFS_MSB:ccd_pkg::OFS_LSB])))
      else $error("phase offset not loaded");
   AST_POWER_DOWN: assert property (
      power_down |=> (!o_channel_output_a && !o_channel_output_b && !o_channel_output_c && o_chan_powered_down))
      else $error("power-down leaves outputs active");
   AST_DIRECT: assert property (
      (direct && !power_down) ##1 (direct && !power_down) |=> o_channel_output_a != $past(o_channel_output_a))
      else $error("direct routing not applied");
   AST_DCC: assert property (
      route_q[ccd_pkg::BIT_DCC_OFF] |=> !o_duty_cycle_fix_on)
      else $error("duty-cycle fix not disabled");
endmodule // ccd_channel_clock_divider

/* File: tb_top.sv */
// Self-checking bench for the channel clock divider.
// Assumes the design's own assertions run alongside; the bench drives every input itself.
`timescale 1ns/1ps
module tb_top;
   ////////////////////////////////////////////////////////////////////////////
   logic i_sys_clk = 1'b0;
   logic i_resetn = 1'b0;
   logic [9:0] i_reg_addr = 10'h000;
   logic [7:0] i_reg_wdata = 8'h00;
   logic i_reg_wr = 1'b0;
   logic i_reg_rd = 1'b0;
   logic i_sync_n = 1'b1;
   logic i_global_route_block = 1'b0;
   logic [7:0] o_reg_rdata;
   logic o_div_clk, o_channel_output_a, o_channel_output_b, o_channel_output_c;
   logic o_chan_powered_down, o_duty_cycle_fix_on;
   int n_errors = 0;
   int total_checks = 0;
   logic [7:0] rd;
   logic lv;
   int n, d0, d5;
   always #2.5 i_sys_clk = ~i_sys_clk;
   ccd_channel_clock_divider dut_u (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_reg_addr(i_reg_addr),
      .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
      .i_sync_n(i_sync_n), .i_global_route_block(i_global_route_block), .o_div_clk(o_div_clk),
      .o_channel_output_a(o_channel_output_a), .o_channel_output_b(o_channel_output_b),
      .o_channel_output_c(o_channel_output_c), .o_chan_powered_down(o_chan_powered_down),
      .o_duty_cycle_fix_on(o_duty_cycle_fix_on));
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string msg);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %0t %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask
   task automatic wr_reg(input logic [9:0] a, input logic [7:0] d);
      @(negedge i_sys_clk);
      i_reg_addr = a;
      i_reg_wdata = d;
      i_reg_wr = 1'b1;
      @(negedge i_sys_clk);
      i_reg_wr = 1'b0;
   endtask
   task automatic rd_reg(input logic [9:0] a, output logic [7:0] d);
      @(negedge i_sys_clk);
      i_reg_addr = a;
      i_reg_rd = 1'b1;
      @(negedge i_sys_clk);
      i_reg_rd = 1'b0;
      @(negedge i_sys_clk);
      d = o_reg_rdata;
   endtask
   task automatic wait_cyc(input int k);
      repeat (k) @(negedge i_sys_clk);
   endtask
   // Waits for the next edge of the divided clock, then times the whole run
   task automatic measure(output logic lvl, output int len);
      int k;
      k = 0;
      lvl = o_div_clk;
      while (o_div_clk === lvl && k < 100) begin
         @(negedge i_sys_clk);
         k++;
      end
      lvl = o_div_clk;
      len = 0;
      while (o_div_clk === lvl && len < 100) begin
         @(negedge i_sys_clk);
         len++;
      end
   endtask
   task automatic runs(input logic [7:0] lo, input logic [7:0] hi, input string msg);
      repeat (2) begin
         measure(lv, n);
         chk(8'(n), lv ? hi : lo, msg);
      end
   endtask
   // Count changes of channel output a over eight cycles
   task automatic toggles(output int t);
      logic p;
      t = 0;
      repeat (8) begin
         p = o_channel_output_a;
         @(negedge i_sys_clk);
         if (o_channel_output_a !== p) t++;
      end
   endtask
   task automatic sync_delay(input logic [7:0] ctl, output int d);
      wr_reg(ccd_pkg::ADDR_DIV_CONTROL, ctl);
      i_sync_n = 1'b0;
      wait_cyc(10);
      chk({7'h00, o_div_clk}, 8'h00, "held at start low");
      i_sync_n = 1'b1;
      d = 0;
      while (o_div_clk === 1'b0 && d < 100) begin
         @(negedge i_sys_clk);
         d++;
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_defaults();
      rd_reg(ccd_pkg::ADDR_PHASE_COUNTS, rd);
      chk(rd, 8'h77, "counts reset");
      rd_reg(ccd_pkg::ADDR_DIV_CONTROL, rd);
      chk(rd, 8'h00, "control reset");
      rd_reg(ccd_pkg::ADDR_ROUTING_POWER, rd);
      chk(rd, 8'h00, "routing reset");
      rd_reg(10'h193, rd);
      chk(rd, 8'h00, "unmapped read");
      chk({7'h00, o_duty_cycle_fix_on}, 8'h01, "fix on by default");
      runs(8'h08, 8'h08, "default run");
      $display("test defaults done");
   endtask
   task automatic t_modes();
      wr_reg(ccd_pkg::ADDR_PHASE_COUNTS, 8'h32);
      wait_cyc(20);
      runs(8'h04, 8'h03, "programmed run");
      wr_reg(ccd_pkg::ADDR_DIV_CONTROL, 8'h80);
      wait_cyc(6);
      measure(lv, n);
      chk(8'(n), 8'h01, "bypass passes input");
      wr_reg(ccd_pkg::ADDR_DIV_CONTROL, 8'h60);
      wait_cyc(8);
      repeat (4) measure(lv, n);
      chk({7'h00, lv}, 8'h01, "forced high");
      wr_reg(ccd_pkg::ADDR_DIV_CONTROL, 8'h20);
      wait_cyc(20);
      runs(8'h04, 8'h03, "force needs ignore");
      wr_reg(ccd_pkg::ADDR_DIV_CONTROL, 8'h40);
      i_sync_n = 1'b0;
      wait_cyc(20);
      runs(8'h04, 8'h03, "sync ignored");
      i_sync_n = 1'b1;
      $display("test modes done");
   endtask
   task automatic t_sync();
      wr_reg(ccd_pkg::ADDR_DIV_CONTROL, 8'h10);
      i_sync_n = 1'b0;
      wait_cyc(10);
      chk({7'h00, o_div_clk}, 8'h01, "held at start high");
      i_sync_n = 1'b1;
      sync_delay(8'h00, d0);
      sync_delay(8'h05, d5);
      chk(8'(d5 - d0), 8'h05, "phase offset");
      wr_reg(ccd_pkg::ADDR_DIV_CONTROL, 8'h00);
      $display("test sync done");
   endtask
   task automatic t_route();
      wr_reg(ccd_pkg::ADDR_ROUTING_POWER, 8'hFF);
      rd_reg(ccd_pkg::ADDR_ROUTING_POWER, rd);
      chk(rd, 8'h07, "routing upper bits");
      wait_cyc(4);
      chk({4'h0, o_chan_powered_down, o_channel_output_a, o_channel_output_b, o_channel_output_c},
         8'h08, "powered down");
      chk({7'h00, o_duty_cycle_fix_on}, 8'h00, "fix off");
      wr_reg(ccd_pkg::ADDR_ROUTING_POWER, 8'h02);
      wait_cyc(4);
      chk({7'h00, o_duty_cycle_fix_on}, 8'h01, "fix back on");
      toggles(n);
      chk(8'(n), 8'h08, "direct route");
      chk({6'h00, o_channel_output_b ^ o_channel_output_a, o_channel_output_c ^ o_channel_output_a},
         8'h00, "outputs equal");
      i_global_route_block = 1'b1;
      wait_cyc(4);
      toggles(n);
      chk({7'h00, n <= 3}, 8'h01, "direct blocked");
      i_global_route_block = 1'b0;
      wr_reg(ccd_pkg::ADDR_ROUTING_POWER, 8'h00);
      $display("test route done");
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      wait_cyc(3);
      i_resetn = 1'b1;
      wait_cyc(4);
      t_defaults();
      t_modes();
      t_sync();
      t_route();
      end_of_test();
   end
   // Whole run is about a thousand cycles; this is well beyond it
   initial begin
      #100000;
      n_errors++;
      $display("[FAIL] %0t watchdog expired", $time);
      end_of_test();
   end
endmodule // tb_top
